// [hdl/gpp_pkg.sv]
// Purpose: Shared constants and types for the eight-pin port control block
// Assumes: One 200 MHz system clock, synchronous register ports
// Notes:   Drive codes, reset-state codes and field positions live here
package gpp_pkg;

  // ==========================================================================
  // Port geometry
  localparam int NPINS      = 8;
  localparam int NOE        = 16;
  localparam int OE_SEL_W   = 4;

  // ==========================================================================
  // Drive mode codes
  typedef enum logic [2:0] {
    GPP_DM_ANALOG_HIZ = 3'h0,
    GPP_DM_DIGITAL_HIZ = 3'h1,
    GPP_DM_PULL_UP    = 3'h2,
    GPP_DM_PULL_DOWN  = 3'h3,
    GPP_DM_OD_LOW     = 3'h4,
    GPP_DM_OD_HIGH    = 3'h5,
    GPP_DM_STRONG     = 3'h6,
    GPP_DM_PULL_BOTH  = 3'h7
  } gpp_drive_t;

  // Pin interrupt edge selection
  typedef enum logic [1:0] {
    GPP_IRQ_OFF  = 2'h0,
    GPP_IRQ_RISE = 2'h1,
    GPP_IRQ_FALL = 2'h2,
    GPP_IRQ_BOTH = 2'h3
  } gpp_edge_t;

  // Reset-state codes held in nonvolatile storage
  localparam logic [1:0] RST_ANALOG = 2'h0;
  localparam logic [1:0] RST_PDOWN  = 2'h1;
  localparam logic [1:0] RST_PUP    = 2'h2;

  // ==========================================================================
  // Pin-form register field layout (8 bits)
  localparam int PF_DR   = 0;
  localparam int PF_PS   = 1;
  localparam int PF_DM0  = 2;
  localparam int PF_DM2  = 4;
  localparam int PF_SLW  = 5;
  localparam int PF_BIE  = 6;
  localparam int PF_IBD  = 7;

  // Special-pin reference choices
  localparam logic [1:0] REF_HALF_VDDIO = 2'h0;
  localparam logic [1:0] REF_04_VDDIO   = 2'h1;
  localparam logic [1:0] REF_HALF_VREF  = 2'h2;
  localparam logic [1:0] REF_VREF       = 2'h3;

endpackage

// [hdl/gpp_pin_cell.sv]
// Purpose: One pin's output driver decode and input gating
// Assumes: Drive code, data and enable come from port registers
// Notes:   Resistive drive is reported apart from strong drive
`timescale 1ns/1ps
`default_nettype none
module gpp_pin_cell (
  // Configuration
  input  wire logic [2:0] drive_code,
  input  wire logic       data_out,
  input  wire logic       bidir_en,
  input  wire logic       aux_oe,
  input  wire logic       slew_slow,
  input  wire logic       in_disable,
  // Pin
  input  wire logic       pin_in,
  output logic            pin_out,
  output logic            pin_oe,
  output logic            pin_pull_up,
  output logic            pin_pull_down,
  output logic            pin_slow,
  output logic            in_val
);
  gpp_pkg::gpp_drive_t dm;
  logic                active;

  always_comb begin
    dm            = gpp_pkg::gpp_drive_t'(drive_code);
    // Bidirectional pins fall back to digital high-Z while the enable is low
    active        = !bidir_en || aux_oe;
    pin_out       = data_out;
    pin_oe        = 1'b0;
    pin_pull_up   = 1'b0;
    pin_pull_down = 1'b0;
    if (active) begin
      unique case (dm)
        gpp_pkg::GPP_DM_ANALOG_HIZ, gpp_pkg::GPP_DM_DIGITAL_HIZ: pin_oe = 1'b0;
        gpp_pkg::GPP_DM_PULL_UP: begin
          pin_oe      = !data_out;
          pin_pull_up = data_out;
        end
        gpp_pkg::GPP_DM_PULL_DOWN: begin
          pin_oe        = data_out;
          pin_pull_down = !data_out;
        end
        gpp_pkg::GPP_DM_OD_LOW:  pin_oe = !data_out;
        gpp_pkg::GPP_DM_OD_HIGH: pin_oe = data_out;
        gpp_pkg::GPP_DM_STRONG:  pin_oe = 1'b1;
        gpp_pkg::GPP_DM_PULL_BOTH: begin
          pin_pull_up   = data_out;
          pin_pull_down = !data_out;
        end
      endcase
    end
    // Slow edges only matter for strong and open-drain drivers
    pin_slow = slew_slow && drive_code[2] && (dm != gpp_pkg::GPP_DM_PULL_BOTH);
    // Analog mode and disabled buffers give a constant low input
    in_val   = pin_in && !in_disable && (dm != gpp_pkg::GPP_DM_ANALOG_HIZ);
  end
endmodule // gpp_pin_cell
`default_nettype wire

// [hdl/gpp_port.sv]
// Purpose: Eight-pin port control with port/pin register views and edge interrupts
// Assumes: Pin inputs and register strobes synchronous to clock
// Notes:   Status clears on read; set wins over clear
`timescale 1ns/1ps
`default_nettype none
module gpp_port (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        rstn,
  // Nonvolatile reset data, power-on release and low-power mode
  input  wire logic [1:0]  nv_reset_state,
  input  wire logic        por_release,
  input  wire logic        low_power,
  // Port-form register writes
  input  wire logic        wr_data,
  input  wire logic        wr_dm0,
  input  wire logic        wr_dm1,
  input  wire logic        wr_dm2,
  input  wire logic        wr_slew,
  input  wire logic        wr_bidir,
  input  wire logic        wr_inoff,
  input  wire logic        wr_irqtype,
  input  wire logic        wr_oesel,
  input  wire logic        wr_cfg,
  input  wire logic [15:0] wdata,
  // Pin-form register access
  input  wire logic        wr_pin,
  input  wire logic [2:0]  pin_index,
  input  wire logic [7:0]  pin_wdata,
  output logic      [7:0]  pin_rdata,
  // Status read strobe
  input  wire logic        rd_status,
  // Port-form read views
  output logic      [7:0]  output_data_register,
  output logic      [7:0]  pin_state_read,
  output logic      [7:0]  drive_mode_select0,
  output logic      [7:0]  drive_mode_select1,
  output logic      [7:0]  drive_mode_select2,
  output logic      [7:0]  edge_rate_select,
  output logic      [7:0]  irq_status,
  output logic      [1:0]  reset_state,
  // Per-port and special pin settings
  output logic             lvttl_sel,
  output logic      [1:0]  ref_sel_pair0,
  output logic      [1:0]  ref_sel_pair1,
  output logic      [1:0]  reg_out_high,
  // Auxiliary control bus
  input  wire logic [15:0] aux_oe,
  // Pins
  input  wire logic [7:0]  pin_in,
  output logic      [7:0]  pin_out,
  output logic      [7:0]  pin_oe,
  output logic      [7:0]  pin_pull_up,
  output logic      [7:0]  pin_pull_down,
  output logic      [7:0]  pin_slow,
  // Port interrupt request
  output logic             port_irq
);
  // ==========================================================================
  // State
  typedef struct packed {
    logic [7:0]      dr;
    logic [7:0][2:0] dm;
    logic [7:0]      slw;
    logic [7:0]      bie;
    logic [7:0]      ibd;
    logic [7:0][1:0] itype;
    logic [7:0][3:0] oesel;
    logic [7:0]      sync1;
    logic [7:0]      sync2;
    logic [7:0]      prev;
    logic [7:0]      stat;
    logic [1:0]      rst_cfg;
    logic            lvttl;
    logic [1:0]      ref0;
    logic [1:0]      ref1;
    logic [1:0]      vreg;
  } gpp_state_t;

  gpp_state_t s_r;
  gpp_state_t s_nxt;
  logic [7:0] in_val;
  logic [7:0] oe_pick;
  logic [7:0] rise;
  logic [7:0] fall;
  logic [7:0] hit;

  // Drive code that a reset-state setting stands for
  function automatic logic [2:0] rst_mode(input logic [1:0] c);
    unique case (c)
      gpp_pkg::RST_PDOWN: rst_mode = gpp_pkg::GPP_DM_PULL_DOWN;
      gpp_pkg::RST_PUP:   rst_mode = gpp_pkg::GPP_DM_PULL_UP;
      default:            rst_mode = gpp_pkg::GPP_DM_ANALOG_HIZ;
    endcase
  endfunction

  // Whether an edge on a pin matches its selected type
  function automatic logic edge_hit(input logic [1:0] t, input logic r, input logic f);
    unique case (gpp_pkg::gpp_edge_t'(t))
      gpp_pkg::GPP_IRQ_RISE: edge_hit = r;
      gpp_pkg::GPP_IRQ_FALL: edge_hit = f;
      gpp_pkg::GPP_IRQ_BOTH: edge_hit = r || f;
      gpp_pkg::GPP_IRQ_OFF:  edge_hit = 1'b0;
    endcase
  endfunction

  // ==========================================================================
  // Pin cells
  genvar g;
  generate
    for (g = 0; g < gpp_pkg::NPINS; g++) begin : g_pin
      assign oe_pick[g] = aux_oe[s_r.oesel[g]];
      gpp_pin_cell u_cell (
        .drive_code    (s_r.dm[g]),
        .data_out      (s_r.dr[g]),
        .bidir_en      (s_r.bie[g]),
        .aux_oe        (oe_pick[g]),
        .slew_slow     (s_r.slw[g]),
        .in_disable    (s_r.ibd[g]),
        .pin_in        (pin_in[g]),
        .pin_out       (pin_out[g]),
        .pin_oe        (pin_oe[g]),
        .pin_pull_up   (pin_pull_up[g]),
        .pin_pull_down (pin_pull_down[g]),
        .pin_slow      (pin_slow[g]),
        .in_val        (in_val[g])
      );
    end
  endgenerate

  // ==========================================================================
  // Next state
  always_comb begin
    s_nxt = s_r;
    // Two-flop synchroniser; edges seen only past the second stage
    s_nxt.sync1 = in_val;
    s_nxt.sync2 = s_r.sync1;
    s_nxt.prev  = s_r.sync2;
    rise = s_r.sync2 & ~s_r.prev;
    fall = ~s_r.sync2 & s_r.prev;
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      hit[i] = edge_hit(s_r.itype[i], rise[i], fall[i]);
    end
    // Detection ignores low_power so a pin can wake the part
    if (rd_status) begin
      s_nxt.stat = 8'h00;
    end
    s_nxt.stat = s_nxt.stat | hit;
    // Low power freezes configuration except the power-on reload; writes made meanwhile are lost
    if (!low_power) begin
      if (wr_data)  s_nxt.dr  = wdata[7:0];
      if (wr_slew)  s_nxt.slw = wdata[7:0];
      if (wr_bidir) s_nxt.bie = wdata[7:0];
      if (wr_inoff) s_nxt.ibd = wdata[7:0];
      for (int i = 0; i < gpp_pkg::NPINS; i++) begin
        if (wr_dm0) s_nxt.dm[i][0] = wdata[i];
        if (wr_dm1) s_nxt.dm[i][1] = wdata[i];
        if (wr_dm2) s_nxt.dm[i][2] = wdata[i];
        if (wr_irqtype) s_nxt.itype[i] = wdata[2*i +: 2];
      end
      if (wr_oesel) begin
        for (int i = 0; i < gpp_pkg::NPINS; i++) begin
          if (wdata[8 + i]) s_nxt.oesel[i] = wdata[3:0];
        end
      end
      if (wr_cfg) begin
        s_nxt.lvttl = wdata[0];
        s_nxt.ref0  = wdata[2:1];
        s_nxt.ref1  = wdata[4:3];
        s_nxt.vreg  = wdata[6:5];
      end
      if (wr_pin) begin
        s_nxt.dr[pin_index]  = pin_wdata[gpp_pkg::PF_DR];
        s_nxt.dm[pin_index]  = pin_wdata[gpp_pkg::PF_DM2:gpp_pkg::PF_DM0];
        s_nxt.slw[pin_index] = pin_wdata[gpp_pkg::PF_SLW];
        s_nxt.bie[pin_index] = pin_wdata[gpp_pkg::PF_BIE];
        s_nxt.ibd[pin_index] = pin_wdata[gpp_pkg::PF_IBD];
      end
    end
    // Power-on release reloads the port's reset drive from storage
    if (por_release) begin
      s_nxt.rst_cfg = nv_reset_state;
      for (int i = 0; i < gpp_pkg::NPINS; i++) begin
        s_nxt.dm[i] = rst_mode(nv_reset_state);
      end
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // ==========================================================================
  // Read views
  always_comb begin
    output_data_register = s_r.dr;
    pin_state_read       = s_r.sync2;
    edge_rate_select     = s_r.slw;
    irq_status           = s_r.stat;
    reset_state          = s_r.rst_cfg;
    lvttl_sel            = s_r.lvttl;
    ref_sel_pair0        = s_r.ref0;
    ref_sel_pair1        = s_r.ref1;
    reg_out_high         = s_r.vreg;
    for (int i = 0; i < gpp_pkg::NPINS; i++) begin
      drive_mode_select0[i] = s_r.dm[i][0];
      drive_mode_select1[i] = s_r.dm[i][1];
      drive_mode_select2[i] = s_r.dm[i][2];
    end
    pin_rdata = {s_r.ibd[pin_index], s_r.bie[pin_index], s_r.slw[pin_index],
                 s_r.dm[pin_index], s_r.sync2[pin_index], s_r.dr[pin_index]};
    port_irq  = |s_r.stat;
  end
endmodule // gpp_port
`default_nettype wire

// [testbench/gpp_port_assertions.sv]
// Purpose: Concurrent checks on the port block's outputs
// Assumes: Bound to gpp_port, one clock domain
// Notes:   Per-pin checks follow the pin picked by pin_index
`timescale 1ns/1ps
`default_nettype none
module gpp_port_assertions (
  // Clock and reset
  input wire logic        clock,
  input wire logic        rstn,
  // Controls
  input wire logic [1:0]  nv_reset_state,
  input wire logic        por_release,
  input wire logic        low_power,
  input wire logic        rd_status,
  input wire logic [2:0]  pin_index,
  input wire logic [15:0] aux_oe,
  // Register views
  input wire logic [7:0]  pin_rdata,
  input wire logic [7:0]  output_data_register,
  input wire logic [7:0]  pin_state_read,
  input wire logic [7:0]  drive_mode_select0,
  input wire logic [7:0]  drive_mode_select1,
  input wire logic [7:0]  drive_mode_select2,
  input wire logic [7:0]  irq_status,
  input wire logic [1:0]  reset_state,
  // Pins and request
  input wire logic [7:0]  pin_out,
  input wire logic [7:0]  pin_oe,
  input wire logic [7:0]  pin_pull_up,
  input wire logic [7:0]  pin_pull_down,
  input wire logic [7:0]  pin_slow,
  input wire logic        port_irq
);
  logic [2:0] md;
  logic       dv, bd, oe, ot, pu, pd;
  assign md = pin_rdata[4:2];
  assign dv = pin_rdata[0];
  assign bd = pin_rdata[6];
  assign oe = pin_oe[pin_index];
  assign ot = pin_out[pin_index];
  assign pu = pin_pull_up[pin_index];
  assign pd = pin_pull_down[pin_index];
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rstn);
  // ==========================================================================
  // Drive decode
  property p_strong; !bd && md == 3'h6 |-> oe && ot == dv; endproperty
  a_strong: assert property (p_strong) else $error("strong drive wrong");
  property p_odrain; !bd && md inside {3'h4, 3'h5} |->
    oe == (md[0] ? dv : !dv) && (!oe || ot == dv); endproperty
  a_odrain: assert property (p_odrain) else $error("open drain wrong");
  property p_resist; !bd && md == 3'h7 |-> !oe && pu == dv && pd == !dv; endproperty
  a_resist: assert property (p_resist) else $error("pull pair wrong");
  property p_slow; !bd |-> pin_slow[pin_index] == (pin_rdata[5] && md inside {[3'h4:3'h6]});
  endproperty
  a_slow: assert property (p_slow) else $error("slow edge wrong");
  property p_bidir; bd && md == 3'h6 && aux_oe == 16'h0000 |-> !oe; endproperty
  a_bidir: assert property (p_bidir) else $error("bidir pin drives");
  // Input gating needs the two sync stages to flush before it shows
  property p_inoff; ((md == 3'h0 || pin_rdata[7]) && $stable(pin_index)) [*3] |-> !pin_rdata[1];
  endproperty
  a_inoff: assert property (p_inoff) else $error("gated input seen");
  // ==========================================================================
  // Interrupts, power and reset load
  property p_edge; (irq_status & ~$past(irq_status)) != 8'h00 |-> ((irq_status &
    ~$past(irq_status)) & ~($past(pin_state_read) ^ $past(pin_state_read, 2))) == 8'h00;
  endproperty
  a_edge: assert property (p_edge) else $error("status without edge");
  property p_clear; rd_status && $stable(pin_state_read) |=> irq_status == 8'h00; endproperty
  a_clear: assert property (p_clear) else $error("status not cleared");
  property p_irq; port_irq == (irq_status != 8'h00); endproperty
  a_irq: assert property (p_irq) else $error("request not status or");
  property p_lp; low_power && !por_release |=>
    $stable(output_data_register) && $stable(drive_mode_select2); endproperty
  a_lp: assert property (p_lp) else $error("state changed in low power");
  property p_por; por_release |=> reset_state == $past(nv_reset_state) &&
    drive_mode_select2 == 8'h00 && drive_mode_select1 == {8{$past(nv_reset_state) != 2'h0}} &&
    drive_mode_select0 == {8{$past(nv_reset_state) == 2'h1}}; endproperty
  a_por: assert property (p_por) else $error("reset data not loaded");
  c_edge: cover property ((irq_status & ~$past(irq_status)) != 8'h00);
  c_clear: cover property (rd_status && irq_status != 8'h00);
  c_por: cover property (por_release && nv_reset_state != 2'h0);
endmodule // gpp_port_assertions
`default_nettype wire

// [testbench/gpp_pins_model.sv]
// Purpose: External circuits at the eight port pins
// Assumes: Bench chooses what the outside world drives
// Notes:   Undriven unpulled pins toggle so no stale level is read
`timescale 1ns/1ps
`default_nettype none
module gpp_pins_model (
  // Clock
  input  wire logic       clock,
  // Port side
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] pin_pull_up,
  input  wire logic [7:0] pin_pull_down,
  // Outside drivers
  input  wire logic [7:0] ext_en,
  input  wire logic [7:0] ext_val,
  output logic      [7:0] pin_in
);
  logic [7:0] flt_r = 8'h00;
  always @(posedge clock) flt_r <= ~flt_r;
  // Port drive wins; the bench keeps outside drivers off driven pins
  always_comb begin
    for (int i = 0; i < 8; i++)
      pin_in[i] = pin_oe[i] ? pin_out[i] : ext_en[i] ? ext_val[i] :
                  pin_pull_up[i] ? 1'b1 : pin_pull_down[i] ? 1'b0 : flt_r[i];
  end
endmodule // gpp_pins_model
`default_nettype wire

// [testbench/tb_top.sv]
// Purpose: Self-checking bench for the eight-pin port block
// Assumes: Pins closed through the external circuit model
// Notes:   Edge interrupts are checked through an expectation queue
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic clock = 1'b0, rstn = 1'b0, por_release = 1'b0, low_power = 1'b0;
  logic wr_pin = 1'b0, rd_status = 1'b0, lvttl_sel, port_irq;
  logic [2:0] pin_index = 3'h0;
  logic [1:0] nv_reset_state = 2'h0, reset_state, ref_sel_pair0, ref_sel_pair1, reg_out_high;
  logic [9:0] wr = 10'h000;
  logic [15:0] wdata = 16'h0000, aux_oe = 16'h0000;
  logic [7:0] pin_wdata = 8'h00, ext_en = 8'h00, ext_val = 8'h00, pin_in, pin_rdata, d, e_oe;
  logic [7:0] output_data_register, pin_state_read, drive_mode_select0, drive_mode_select1;
  logic [7:0] drive_mode_select2, edge_rate_select, irq_status, pin_out, pin_oe;
  logic [7:0] pin_pull_up, pin_pull_down, pin_slow, prev_st = 8'h00;
  logic [7:0] irq_q[$];
  int n_fail = 0, n_tests = 0, seed = 64403;
  always #2.5 clock = ~clock;
  gpp_port gpp_port_i (.clock, .rstn, .nv_reset_state, .por_release, .low_power,
    .wr_data(wr[0]), .wr_dm0(wr[1]), .wr_dm1(wr[2]), .wr_dm2(wr[3]), .wr_slew(wr[4]),
    .wr_bidir(wr[5]), .wr_inoff(wr[6]), .wr_irqtype(wr[7]), .wr_oesel(wr[8]), .wr_cfg(wr[9]),
    .wdata, .wr_pin, .pin_index, .pin_wdata, .pin_rdata, .rd_status, .output_data_register,
    .pin_state_read, .drive_mode_select0, .drive_mode_select1, .drive_mode_select2,
    .edge_rate_select, .irq_status, .reset_state, .lvttl_sel, .ref_sel_pair0,
    .ref_sel_pair1, .reg_out_high, .aux_oe, .pin_in, .pin_out, .pin_oe, .pin_pull_up,
    .pin_pull_down, .pin_slow, .port_irq);
  gpp_pins_model gpp_pins_model_i (.clock, .pin_out, .pin_oe, .pin_pull_up,
    .pin_pull_down, .ext_en, .ext_val, .pin_in);
  task automatic cmp(input string nm, input logic [7:0] ex, input logic [7:0] got);
    n_tests++;
    if (got !== ex) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, ex, got);
    end
  endtask
  task automatic print_verdict;
    if (n_fail == 0 && n_tests > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic pw(input int s, input logic [15:0] v);
    tick(1);
    wr[s] = 1'b1;
    wdata = v;
    tick(1);
    wr[s] = 1'b0;
  endtask
  task automatic pp(input logic [2:0] k, input logic [7:0] v);
    tick(1);
    wr_pin = 1'b1;
    pin_index = k;
    pin_wdata = v;
    tick(1);
    wr_pin = 1'b0;
  endtask
  task automatic setdm(input int m);
    for (int b = 0; b < 3; b++) pw(b + 1, {8'h00, {8{m[b]}}});
  endtask
  task automatic drain;
    for (int i = 0; i < 20 && irq_q.size() != 0; i++) tick(1);
    cmp("irq_wait", 8'h00, 8'(irq_q.size()));
    if (irq_q.size() != 0) print_verdict();
  endtask
  // Any change to a nonzero status not announced in the queue is compared against zero
  always @(posedge clock) begin
    if (irq_status !== prev_st && irq_status !== 8'h00) begin
      if (irq_q.size() == 0) cmp("irq_status", 8'h00, irq_status);
      else cmp("irq_status", irq_q.pop_front(), irq_status);
    end
    prev_st <= irq_status;
  end
  initial begin
    tick(20000);
    cmp("run_time", 8'h00, 8'h01);
    print_verdict();
  end
  initial begin
    tick(12);
    rstn = 1'b1;
    cmp("dm_reset", 8'h00, drive_mode_select2 | drive_mode_select1 | drive_mode_select0);
    cmp("oe_reset", 8'h00, pin_oe | 8'(port_irq));
    for (int n = 2; n >= 0; n--) begin
      nv_reset_state = n[1:0];
      por_release = 1'b1;
      tick(1);
      por_release = 1'b0;
      cmp("reset_state", 8'(n), 8'(reset_state));
      cmp("dm1_por", n != 0 ? 8'hFF : 8'h00, drive_mode_select1);
    end
    pw(4, 16'h00FF);
    for (int m = 0; m < 8; m++) begin
      d = 8'($random(seed));
      pw(0, {8'h00, d});
      setdm(m);
      tick(3);
      e_oe = (m == 6) ? 8'hFF : (m == 3 || m == 5) ? d : (m == 2 || m == 4) ? ~d : 8'h00;
      cmp("output_data", d, output_data_register);
      cmp("pin_oe", e_oe, pin_oe);
      cmp("pin_out", e_oe & d, pin_out & e_oe);
      cmp("pull_up", (m == 2 || m == 7) ? d : 8'h00, pin_pull_up);
      cmp("pull_down", (m == 3 || m == 7) ? ~d : 8'h00, pin_pull_down);
      cmp("pin_slow", (m > 3 && m < 7) ? 8'hFF : 8'h00, pin_slow);
      if (m == 0 || m == 6) cmp("pin_state", m != 0 ? d : 8'h00, pin_state_read);
    end
    pp(3'h3, 8'h19);
    cmp("pin_rdata", 8'h19, pin_rdata & 8'hFD);
    cmp("port_views", 8'h0D, {3'h0, edge_rate_select[3], drive_mode_select2[3],
      drive_mode_select1[3], drive_mode_select0[3], output_data_register[3]});
    pp(3'h5, 8'h59);
    pw(8, 16'h2009);
    tick(1);
    cmp("bidir_off", 8'h00, 8'(pin_oe[5]));
    for (int i = 0; i < 8; i++) begin
      aux_oe = 16'($random(seed));
      tick(1);
      cmp("bidir_oe", 8'(aux_oe[9]), 8'(pin_oe[5]));
    end
    aux_oe = 16'h0000;
    setdm(1);
    ext_en = 8'hFF;
    tick(4);
    pw(7, 16'hE4E4);
    pw(6, 16'h0002);
    low_power = 1'b1;
    e_oe = output_data_register;
    pw(0, 16'h00AA);
    cmp("lp_refused", e_oe, output_data_register);
    irq_q.push_back(8'hA8);
    ext_val = 8'hFF;
    drain;
    cmp("port_irq", 8'h01, 8'(port_irq));
    cmp("in_disable", 8'hFD, pin_state_read);
    rd_status = 1'b1;
    tick(1);
    rd_status = 1'b0;
    cmp("irq_clear", 8'h00, irq_status | 8'(port_irq));
    irq_q.push_back(8'hCC);
    ext_val = 8'h00;
    drain;
    low_power = 1'b0;
    for (int r = 0; r < 4; r++) begin
      pw(9, {9'h000, r[1:0], r[1:0], r[1:0], r[0]});
      cmp("cfg", {1'b0, r[1:0], r[1:0], r[1:0], r[0]},
        {1'b0, reg_out_high, ref_sel_pair1, ref_sel_pair0, lvttl_sel});
    end
    print_verdict();
  end
endmodule // tb_top

// Checker sees only the port block's own ports
bind gpp_port gpp_port_assertions gpp_port_assertions_i (.clock, .rstn, .nv_reset_state,
  .por_release, .low_power, .rd_status, .pin_index, .aux_oe, .pin_rdata,
  .output_data_register, .pin_state_read, .drive_mode_select0, .drive_mode_select1,
  .drive_mode_select2, .irq_status, .reset_state, .pin_out, .pin_oe, .pin_pull_up,
  .pin_pull_down, .pin_slow, .port_irq);
`default_nettype wire
